// >>> common/position_counter_pkg.sv
// constants, field layout and carrier types for the quadrature position channel
// assumes a 10 MHz clock and a synchronous host register port
// How it works
// - any reset clears the whole setup register, leaving the channel disabled
// - setup register reads and writes work as 16-bit or single-byte transfers
// - ten channels exist, each a 16-bit count with its own setup register
// - mode field bits 2..0 equal to 001 selects quadrature counting
// - count up when A leads B, down when B leads A
// - single resolution: up on A rising while A leads, down on A falling
// - double resolution: step on both edges of A, direction from phase
// - quadruple resolution: step on every edge of A and of B
// - bits 5..4 choose A handling: off, single, double, quadruple
// - bit 6 enables channel B; zero disables it
// - counting starts only after a software trigger write to this channel's bit
// - index high in the selected phase loads the count from reload value
// - bit 3 sets output active level; undriven output rests high
// - live count register returns the counter at each read
// - interrupt on index or count match, only when bit 15 and type allow
// - pending interrupt stays until cleared by write or by clearing bit 15
// - interrupt re-raises at once after clear while its condition holds
// - bits 11..10: none, count match, index with reload, index without reload
// - bit 13 rejects A, B or index pulses of at most 2.5 us
package position_counter_pkg;
    localparam int CHAN_COUNT = 10;
    localparam int COUNT_W = 16;
    // register indices on the host port
    localparam logic [2:0] ADDR_SETUP = 3'h0;
    localparam logic [2:0] ADDR_PRESET_A = 3'h1;
    localparam logic [2:0] ADDR_RELOAD_B = 3'h2;
    localparam logic [2:0] ADDR_LIVE = 3'h3;
    localparam logic [2:0] ADDR_TRIGGER = 3'h4;
    localparam logic [2:0] ADDR_PENDING = 3'h5;
    // reset values and masks
    localparam logic [15:0] SETUP_RESET = 16'h0000;
    localparam logic [15:0] SETUP_WRITABLE = 16'hAFFF;
    localparam logic [15:0] PRESET_RESET = 16'h0000;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    // field codes
    localparam logic [2:0] MODE_QUAD = 3'h1;
    localparam logic [1:0] RES_OFF = 2'h0;
    localparam logic [1:0] RES_X1 = 2'h1;
    localparam logic [1:0] RES_X2 = 2'h2;
    localparam logic [1:0] RES_X4 = 2'h3;
    localparam logic [2:0] PH_A0B1 = 3'h1;
    localparam logic [2:0] PH_A1B0 = 3'h2;
    localparam logic [2:0] PH_A1B1 = 3'h3;
    localparam logic [2:0] PH_A0B0 = 3'h4;
    localparam logic [1:0] COND_NONE = 2'h0;
    localparam logic [1:0] COND_MATCH = 2'h1;
    localparam logic [1:0] COND_IDX_LOAD = 2'h2;
    localparam logic [1:0] COND_IDX = 2'h3;
    // timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int DEB_TIME_NS = 2500;
    localparam int DEB_CYCLES = DEB_TIME_NS / CLK_PERIOD_NS;
    // setup register layout
    typedef struct packed {
        logic irq_en;
        logic rsv14;
        logic deb_en;
        logic rsv12;
        logic [1:0] cond;
        logic [2:0] phase;
        logic b_en;
        logic [1:0] res;
        logic pol;
        logic [2:0] mode;
    } setup_t;
    // one host access
    typedef struct packed {
        logic [2:0] addr;
        logic wr;
        logic rd;
        logic [1:0] be;
        logic [15:0] wdata;
    } host_req_t;
    typedef enum {CH_IDLE, CH_RUN} chan_state_t;
endpackage

// >>> design/glitch_filter.sv
// pulse reject filter for one encoder input
// assumes the input is synchronous to clk
`timescale 1ns/1ps
`default_nettype none
module glitch_filter
    import position_counter_pkg::*;
#(
    parameter int CYCLES = DEB_CYCLES
)
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // control and data
    input wire logic en,
    input wire logic raw,
    output logic filt
);
    localparam int CW = $clog2(CYCLES + 1);

    if (CYCLES < 1)
    begin : bad_cycles
        $error("filter length must be at least one cycle");
    end

    logic [CW-1:0] cnt;
    logic [CW-1:0] next_cnt;
    logic next_filt;

    // a change is taken once it has held longer than CYCLES samples
    always_comb
    begin
        next_cnt = '0;
        next_filt = filt;
        if (!en)
        begin
            next_filt = raw;
        end
        else if (raw != filt)
        begin
            if (cnt == CW'(CYCLES))
            begin
                next_filt = raw;
            end
            else
            begin
                next_cnt = cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            cnt <= '0;
            filt <= 1'b0;
        end
        else
        begin
            cnt <= next_cnt;
            filt <= next_filt;
        end
    end
endmodule
`default_nettype wire

// >>> design/quad_step_decode.sv
// turns A/B transitions into up and down steps
// assumes filtered inputs synchronous to clk
`timescale 1ns/1ps
`default_nettype none
module quad_step_decode
    import position_counter_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // control
    input wire logic en,
    input wire logic [1:0] res,
    input wire logic b_en,
    // channels
    input wire logic a,
    input wire logic b,
    // steps
    output logic step_up,
    output logic step_dn
);
    logic prev_a;
    logic prev_b;
    logic cur_b;
    logic a_chg;
    logic b_chg;
    logic fwd;

    always_comb
    begin
        cur_b = b_en & b;
        a_chg = a != prev_a;
        b_chg = cur_b != prev_b;
        fwd = a ^ prev_b;
        step_up = 1'b0;
        step_dn = 1'b0;
        unique case (res)
            RES_OFF:
            begin
                step_up = 1'b0;
            end
            RES_X1:
            begin
                step_up = a_chg & !b_chg & a & fwd;
                step_dn = a_chg & !b_chg & !a & !fwd;
            end
            RES_X2:
            begin
                step_up = a_chg & !b_chg & fwd;
                step_dn = a_chg & !b_chg & !fwd;
            end
            RES_X4:
            begin
                step_up = (a_chg ^ b_chg) & fwd;
                step_dn = (a_chg ^ b_chg) & !fwd;
            end
        endcase
        step_up = step_up & en;
        step_dn = step_dn & en;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            prev_a <= 1'b0;
            prev_b <= 1'b0;
        end
        else
        begin
            prev_a <= a;
            prev_b <= cur_b;
        end
    end
endmodule
`default_nettype wire

// >>> design/quadrature_position_counter.sv
// one counter/timer channel in quadrature position mode
// assumes host port and encoder inputs synchronous to clk; output pin has a pull-up
`timescale 1ns/1ps
`default_nettype none
module quadrature_position_counter
    import position_counter_pkg::*;
#(
    parameter int CHAN_INDEX = 0,
    parameter int NUM_CHANNELS = CHAN_COUNT
)
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // host register port
    input wire position_counter_pkg::host_req_t host_req,
    output logic [15:0] host_rdata,
    output logic host_rvalid,
    // encoder
    input wire logic encoder_in_a,
    input wire logic encoder_in_b,
    input wire logic index_in,
    // channel output and interrupt
    output logic chan_out,
    output logic chan_out_en,
    output logic irq_out
);
    import position_counter_pkg::*;

    if (NUM_CHANNELS != CHAN_COUNT || CHAN_INDEX < 0 || CHAN_INDEX >= NUM_CHANNELS || CHAN_INDEX > 15)
    begin : bad_index
        $error("channel index outside the ten channels");
    end

    localparam int LANE = CHAN_INDEX / 8;

    setup_t setup;
    setup_t next_setup;
    logic [15:0] preset_a;
    logic [15:0] next_preset_a;
    logic [15:0] reload_b;
    logic [15:0] next_reload_b;
    logic [15:0] count;
    logic [15:0] next_count;
    chan_state_t state;
    chan_state_t next_state;
    logic next_irq;
    logic next_out;
    logic next_out_en;
    logic [15:0] next_rdata;
    logic next_rvalid;
    logic a_f;
    logic b_f;
    logic idx_f;
    logic step_up;
    logic step_dn;
    logic running;
    logic trigger_hit;
    logic clear_hit;
    logic phase_match;
    logic index_true;
    logic reload;
    logic cond_true;
    logic full_word;

    // input filters
    glitch_filter #(.CYCLES(DEB_CYCLES)) filt_a (
        .clk(clk),
        .rst_n(rst_n),
        .en(setup.deb_en),
        .raw(encoder_in_a),
        .filt(a_f)
    );
    glitch_filter #(.CYCLES(DEB_CYCLES)) filt_b (
        .clk(clk),
        .rst_n(rst_n),
        .en(setup.deb_en),
        .raw(encoder_in_b),
        .filt(b_f)
    );
    glitch_filter #(.CYCLES(DEB_CYCLES)) filt_idx (
        .clk(clk),
        .rst_n(rst_n),
        .en(setup.deb_en),
        .raw(index_in),
        .filt(idx_f)
    );

    quad_step_decode decode (
        .clk(clk),
        .rst_n(rst_n),
        .en(running),
        .res(setup.res),
        .b_en(setup.b_en),
        .a(a_f),
        .b(b_f),
        .step_up(step_up),
        .step_dn(step_dn)
    );

    // host write decode and register file
    always_comb
    begin
        full_word = host_req.be == 2'h3;
        trigger_hit = host_req.wr && host_req.addr == ADDR_TRIGGER && host_req.be[LANE]
            && host_req.wdata[CHAN_INDEX];
        clear_hit = host_req.wr && host_req.addr == ADDR_PENDING && host_req.be[LANE]
            && host_req.wdata[CHAN_INDEX];
        next_setup = setup;
        next_preset_a = preset_a;
        next_reload_b = reload_b;
        if (host_req.wr && host_req.addr == ADDR_SETUP)
        begin
            if (host_req.be[0])
            begin
                next_setup[7:0] = host_req.wdata[7:0];
            end
            if (host_req.be[1])
            begin
                next_setup[15:8] = host_req.wdata[15:8] & SETUP_WRITABLE[15:8];
            end
        end
        if (host_req.wr && full_word && host_req.addr == ADDR_PRESET_A)
        begin
            next_preset_a = host_req.wdata;
        end
        if (host_req.wr && full_word && host_req.addr == ADDR_RELOAD_B)
        begin
            next_reload_b = host_req.wdata;
        end
    end

    // read path
    always_comb
    begin
        next_rdata = 16'h0000;
        next_rvalid = host_req.rd;
        if (host_req.rd)
        begin
            unique case (host_req.addr)
                ADDR_SETUP: next_rdata = setup;
                ADDR_PRESET_A: next_rdata = preset_a;
                ADDR_RELOAD_B: next_rdata = reload_b;
                ADDR_LIVE: next_rdata = count;
                ADDR_PENDING: next_rdata = 16'(irq_out) << CHAN_INDEX;
                default: next_rdata = 16'h0000;
            endcase
        end
    end

    // start and stop
    always_comb
    begin
        next_state = state;
        unique case (state)
            CH_IDLE:
            begin
                if (trigger_hit && setup.mode == MODE_QUAD)
                begin
                    next_state = CH_RUN;
                end
            end
            CH_RUN:
            begin
                if (setup.mode != MODE_QUAD)
                begin
                    next_state = CH_IDLE;
                end
            end
        endcase
    end

    // index, counting, interrupt and output
    always_comb
    begin
        running = state == CH_RUN;
        unique case (setup.phase)
            PH_A0B1: phase_match = !a_f && b_f;
            PH_A1B0: phase_match = a_f && !b_f;
            PH_A1B1: phase_match = a_f && b_f;
            PH_A0B0: phase_match = !a_f && !b_f;
            default: phase_match = 1'b0;
        endcase
        index_true = idx_f && phase_match;
        reload = running && setup.cond == COND_IDX_LOAD && index_true;
        unique case (setup.cond)
            COND_NONE: cond_true = 1'b0;
            COND_MATCH: cond_true = count == preset_a;
            COND_IDX_LOAD: cond_true = index_true;
            COND_IDX: cond_true = index_true;
        endcase
        cond_true = cond_true && running;
        next_count = count;
        if (reload)
        begin
            next_count = reload_b;
        end
        else if (step_up)
        begin
            next_count = count + 16'h0001;
        end
        else if (step_dn)
        begin
            next_count = count - 16'h0001;
        end
        // set wins over clear while the condition still holds
        next_irq = (setup.irq_en && cond_true) || (irq_out && !clear_hit && setup.irq_en);
        next_out_en = cond_true;
        next_out = cond_true ? setup.pol : 1'b1;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            setup <= setup_t'(SETUP_RESET);
            preset_a <= PRESET_RESET;
            reload_b <= PRESET_RESET;
            count <= COUNT_RESET;
            state <= CH_IDLE;
            irq_out <= 1'b0;
            chan_out <= 1'b1;
            chan_out_en <= 1'b0;
            host_rdata <= 16'h0000;
            host_rvalid <= 1'b0;
        end
        else
        begin
            setup <= next_setup;
            preset_a <= next_preset_a;
            reload_b <= next_reload_b;
            count <= next_count;
            state <= next_state;
            irq_out <= next_irq;
            chan_out <= next_out;
            chan_out_en <= next_out_en;
            host_rdata <= next_rdata;
            host_rvalid <= next_rvalid;
        end
    end

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    setup_reset_a: assert property (disable iff (1'b0) !rst_n |=> setup == SETUP_RESET)
        else $error("setup not cleared by reset");
    byte_write_a: assert property (host_req.wr && host_req.addr == ADDR_SETUP && host_req.be == 2'h1
        |=> setup[15:8] == $past(setup[15:8]) && setup[7:0] == $past(host_req.wdata[7:0]))
        else $error("low byte write disturbed high byte");
    mode_stop_a: assert property (setup.mode != MODE_QUAD |=> state == CH_IDLE)
        else $error("channel runs outside quadrature mode");
    idle_hold_a: assert property (state == CH_IDLE && !trigger_hit
        |=> state == CH_IDLE && count == $past(count))
        else $error("count moved without trigger");
    x4_up_a: assert property (running && setup.res == RES_X4 && step_up && !reload
        |=> count == $past(count) + 16'h0001)
        else $error("quadruple step not counted");
    x1_edge_a: assert property (step_up && setup.res == RES_X1 |-> $rose(a_f))
        else $error("single resolution up step off A rising edge");
    x2_edge_a: assert property ((step_up || step_dn) && setup.res == RES_X2 |-> $changed(a_f))
        else $error("double resolution step without A edge");
    index_load_a: assert property (reload |=> count == $past(reload_b))
        else $error("index reload missed");
    out_level_a: assert property (chan_out_en |-> chan_out == $past(setup.pol))
        else $error("output level against polarity");
    out_rest_a: assert property (!chan_out_en |-> chan_out)
        else $error("undriven output not high");
    live_read_a: assert property (host_req.rd && host_req.addr == ADDR_LIVE
        |=> host_rvalid && host_rdata == $past(count))
        else $error("live count read wrong");
    irq_gate_a: assert property (!setup.irq_en |=> !irq_out)
        else $error("interrupt while disabled");
    irq_hold_a: assert property (irq_out && !clear_hit && setup.irq_en |=> irq_out)
        else $error("pending interrupt lost");
    irq_rearm_a: assert property (clear_hit && setup.irq_en && cond_true |=> irq_out)
        else $error("interrupt not re-raised");
    wrap_up_a: assert property (count == 16'hFFFF && step_up && !reload |=> count == 16'h0000)
        else $error("count did not wrap");
    wrap_dn_a: assert property (count == 16'h0000 && step_dn && !step_up && !reload |=> count == 16'hFFFF)
        else $error("count did not wrap downward");
    x4_dn_a: assert property (running && setup.res == RES_X4 && step_dn && !reload
        |=> count == $past(count) - 16'h0001) else $error("quadruple down step not counted");
    trigger_start_a: assert property (state == CH_IDLE && trigger_hit && setup.mode == MODE_QUAD |=> running)
        else $error("trigger did not start the channel");
    res_off_a: assert property (setup.res == RES_OFF |-> !step_up && !step_dn)
        else $error("step with channel A disabled");
    irq_clear_a: assert property (irq_out && clear_hit && !cond_true |=> !irq_out)
        else $error("clear write did not release interrupt");
    idx_off_a: assert property (setup.phase == 3'h0 || setup.phase > 3'h4 |-> !reload)
        else $error("reload with index phase disabled");
    pend_read_a: assert property (host_req.rd && host_req.addr == ADDR_PENDING
        |=> host_rdata[CHAN_INDEX] == $past(irq_out)) else $error("pending bit read wrong");
    out_match_a: assert property (running && setup.cond == COND_MATCH && count == preset_a |=> chan_out_en)
        else $error("output not driven on count match");
    rvalid_pulse_a: assert property (host_rvalid |-> $past(host_req.rd))
        else $error("read answer without read strobe");

    reload_seen_c: cover property (reload ##1 irq_out);
    wrap_seen_c: cover property (count == 16'h0000 && step_dn);
    irq_clear_c: cover property (irq_out && clear_hit ##1 !irq_out);
    x4_run_c: cover property (running && setup.res == RES_X4 && step_dn);
    match_seen_c: cover property (running && setup.cond == COND_MATCH && cond_true);
endmodule
`default_nettype wire

// >>> testbench/quad_encoder_model.sv
// behavioural quadrature encoder with index channel and a glitch injector on A
// assumes bench commands arrive by non-blocking assignment at posedge clk
`timescale 1ns/1ps
`default_nettype none
module quad_encoder_model
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // motion command
    input wire logic go,
    input wire logic dir,
    input wire logic [7:0] quarters,
    input wire logic [7:0] hold,
    // index and fault injection
    input wire logic idx_en,
    input wire logic [1:0] idx_ab,
    input wire logic glitch,
    // encoder pins
    output logic enc_a,
    output logic enc_b,
    output logic enc_idx,
    output logic busy
);
    logic [1:0] ph;
    logic [7:0] left;
    logic [7:0] wait_cnt;
    // walk 00,10,11,01 upward: a leads b
    assign enc_a = (ph[0] ^ ph[1]) ^ glitch;
    assign enc_b = ph[1];
    // index high for the whole chosen phase
    assign enc_idx = idx_en && ({ph[0] ^ ph[1], ph[1]} == idx_ab);
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            ph <= 2'h0;
            left <= 8'h00;
            wait_cnt <= 8'h00;
            busy <= 1'b0;
        end
        else if (!busy)
        begin
            if (go && quarters != 8'h00)
            begin
                left <= quarters;
                wait_cnt <= hold;
                busy <= 1'b1;
            end
        end
        else if (wait_cnt > 8'h01)
            wait_cnt <= wait_cnt - 8'h01;
        else
        begin
            ph <= dir ? ph + 2'h1 : ph - 2'h1;
            wait_cnt <= hold;
            left <= left - 8'h01;
            busy <= (left != 8'h01);
        end
    end
endmodule
`default_nettype wire

// >>> testbench/quadrature_position_counter_tb.sv
// self-checking bench for the quadrature position channel
// assumes the encoder model drives the A, B and index pins
`timescale 1ns/1ps
`default_nettype none
module quadrature_position_counter_tb;
    import position_counter_pkg::*;
    localparam int CH = 9;
    logic clk;
    logic rst_n;
    host_req_t req;
    logic [15:0] rdata;
    logic rvalid, ea, eb, ei, cout, cout_en, irq;
    logic go, dir, idx_en, glitch, busy, up;
    logic [7:0] qn, hold;
    logic [1:0] idx_ab;
    logic [15:0] exp_cnt, rd, v;
    int mismatches, check_count, seed, n;
    int tp_tab[8] = '{0, 3, 1, 2, 0, 0, 0, 0};
    logic [1:0] ab_tab[8] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h0, 2'h0, 2'h0, 2'h0};

    quadrature_position_counter #(.CHAN_INDEX(CH), .NUM_CHANNELS(CHAN_COUNT)) quadrature_position_counter_inst (
        .clk(clk), .rst_n(rst_n), .host_req(req), .host_rdata(rdata), .host_rvalid(rvalid),
        .encoder_in_a(ea), .encoder_in_b(eb), .index_in(ei),
        .chan_out(cout), .chan_out_en(cout_en), .irq_out(irq));
    quad_encoder_model quad_encoder_model_inst (.clk(clk), .rst_n(rst_n), .go(go), .dir(dir),
        .quarters(qn), .hold(hold), .idx_en(idx_en), .idx_ab(idx_ab), .glitch(glitch),
        .enc_a(ea), .enc_b(eb), .enc_idx(ei), .busy(busy));

    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic close_out;
        $display("checks=%0d mismatches=%0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial
    begin
        repeat (40000) @(posedge clk);
        mismatches++;
        close_out();
    end

    task automatic check(input logic [15:0] got, input logic [15:0] want);
        check_count++;
        if (got !== want)
        begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, want);
        end
    endtask

    task automatic wr(input logic [2:0] a, input logic [1:0] be, input logic [15:0] d);
        req <= {a, 1'b1, 1'b0, be, d};
        @(posedge clk);
        req <= '0;
        @(posedge clk);
    endtask

    // read answer stands just after the edge that takes the strobe
    task automatic rdr(input logic [2:0] a, output logic [15:0] d);
        req <= {a, 1'b0, 1'b1, 2'b11, 16'h0000};
        @(posedge clk);
        req <= '0;
        #1;
        check({15'h0000, rvalid}, 16'h0001);
        d = rdata;
        @(posedge clk);
    endtask

    // irq, pin level, pin enable sampled mid-cycle
    task automatic look(input logic [2:0] w);
        @(negedge clk);
        check({13'h0000, irq, cout, cout_en}, {13'h0000, w});
        @(posedge clk);
    endtask

    task automatic move(input logic d, input int q, input int h);
        dir <= d;
        qn <= 8'(q);
        hold <= 8'(h);
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        @(posedge clk);
        while (busy === 1'b1)
            @(posedge clk);
        repeat (32) @(posedge clk);
    endtask

    function automatic int spq(input logic [1:0] r);
        return (r == RES_X1) ? 1 : (r == RES_X2) ? 2 : (r == RES_X4) ? 4 : 0;
    endfunction

    function automatic logic [15:0] su(input int ie, input int deb, input logic [1:0] cond,
        input logic [2:0] phs, input int b_on, input int pol, input logic [1:0] res);
        return {ie[0], 1'b0, deb[0], 1'b0, cond, phs, b_on[0], res, pol[0], MODE_QUAD};
    endfunction

    initial
    begin
        seed = 92;
        rst_n = 1'b0;
        req = '0;
        go = 1'b0;
        dir = 1'b0;
        qn = 8'h00;
        hold = 8'h02;
        idx_en = 1'b0;
        idx_ab = 2'h0;
        glitch = 1'b0;
        exp_cnt = 16'h0000;
        mismatches = 0;
        check_count = 0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rdr(ADDR_SETUP, rd);
        check(rd, SETUP_RESET);
        rdr(ADDR_LIVE, rd);
        check(rd, COUNT_RESET);
        look(3'b010);
        v = 16'($random(seed));
        wr(ADDR_SETUP, 2'b01, v);
        rdr(ADDR_SETUP, rd);
        check(rd, {8'h00, v[7:0]});
        wr(ADDR_SETUP, 2'b10, ~v);
        rdr(ADDR_SETUP, rd);
        check(rd, {~v[15:8], v[7:0]} & SETUP_WRITABLE);
        $display("test reset and byte lanes done");
        wr(ADDR_SETUP, 2'b11, su(0, 0, COND_NONE, 3'h0, 1, 0, RES_X4));
        wr(ADDR_TRIGGER, 2'b01, 16'h0200);
        move(1'b1, 4, 2);
        rdr(ADDR_LIVE, rd);
        check(rd, exp_cnt);
        wr(ADDR_TRIGGER, 2'b11, 16'h0200);
        for (int i = 0; i < 12; i++)
        begin
            up = (i == 1) ? 1'b0 : 1'($random(seed));
            n = 1 + ($unsigned($random(seed)) % 4);
            wr(ADDR_SETUP, 2'b11, su(0, 0, COND_NONE, 3'h0, 1, 0, 2'(i % 4)));
            move(up, 4 * n, 2 + ($unsigned($random(seed)) % 4));
            v = 16'(n * spq(2'(i % 4)));
            exp_cnt = up ? exp_cnt + v : exp_cnt - v;
            rdr(ADDR_LIVE, rd);
            check(rd, exp_cnt);
        end
        wr(ADDR_SETUP, 2'b11, su(0, 0, COND_NONE, 3'h0, 0, 0, RES_X1));
        move(1'b1, 4, 3);
        rdr(ADDR_LIVE, rd);
        check(rd, exp_cnt);
        $display("test resolutions done");
        wr(ADDR_SETUP, 2'b11, su(0, 1, COND_NONE, 3'h0, 1, 0, RES_X4));
        glitch <= 1'b1;
        repeat (20) @(posedge clk);
        glitch <= 1'b0;
        repeat (40) @(posedge clk);
        rdr(ADDR_LIVE, rd);
        check(rd, exp_cnt);
        move(1'b1, 4, 30);
        exp_cnt = exp_cnt + 16'h0004;
        rdr(ADDR_LIVE, rd);
        check(rd, exp_cnt);
        $display("test filter done");
        for (int c = 1; c < 8; c++)
        begin
            v = 16'($random(seed));
            wr(ADDR_RELOAD_B, 2'b11, v);
            wr(ADDR_SETUP, 2'b11, su(0, 0, COND_IDX_LOAD, 3'(c), 1, c[0], RES_X4));
            move(1'b1, tp_tab[c], 2);
            exp_cnt = exp_cnt + 16'(tp_tab[c]);
            idx_ab <= ab_tab[c];
            idx_en <= 1'b1;
            repeat (6) @(posedge clk);
            look((c < 5) ? {1'b0, c[0], 1'b1} : 3'b010);
            if (c < 5)
                exp_cnt = v;
            rdr(ADDR_LIVE, rd);
            check(rd, exp_cnt);
            idx_en <= 1'b0;
            move(1'b0, tp_tab[c], 2);
            exp_cnt = exp_cnt - 16'(tp_tab[c]);
        end
        $display("test index reload done");
        wr(ADDR_RELOAD_B, 2'b11, ~exp_cnt);
        wr(ADDR_SETUP, 2'b11, su(1, 0, COND_IDX, PH_A0B0, 1, 0, RES_X4));
        idx_ab <= 2'h0;
        idx_en <= 1'b1;
        repeat (6) @(posedge clk);
        look(3'b101);
        wr(ADDR_PENDING, 2'b11, 16'h0200);
        look(3'b101);
        idx_en <= 1'b0;
        repeat (6) @(posedge clk);
        look(3'b110);
        wr(ADDR_PENDING, 2'b11, 16'h0200);
        look(3'b010);
        rdr(ADDR_LIVE, rd);
        check(rd, exp_cnt);
        wr(ADDR_PRESET_A, 2'b11, exp_cnt + 16'h0004);
        wr(ADDR_SETUP, 2'b11, su(0, 0, COND_MATCH, 3'h0, 1, 1, RES_X4));
        move(1'b1, 4, 2);
        look(3'b011);
        wr(ADDR_SETUP, 2'b11, su(1, 0, COND_MATCH, 3'h0, 1, 1, RES_X4));
        repeat (3) @(posedge clk);
        look(3'b111);
        wr(ADDR_SETUP, 2'b11, su(0, 0, COND_MATCH, 3'h0, 1, 1, RES_X4));
        repeat (3) @(posedge clk);
        look(3'b011);
        $display("test interrupts done");
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rdr(ADDR_SETUP, rd);
        check(rd, SETUP_RESET);
        rdr(ADDR_LIVE, rd);
        check(rd, COUNT_RESET);
        look(3'b010);
        $display("test reset in run done");
        close_out();
    end
endmodule
`default_nettype wire
